//--- logic/uisr_params.svh
/*
 Offsets, field positions, reset values and sizes for the UART
 interrupt identification and line status block.
 Assumes byte addressing on a 32-bit Avalon-MM slave.
*/
// Notes on behaviour
// - identification bits 7:6 read 00 fifo off, 10 fifo on with multidrop, 11 fifo on.
// - cause code in bits 3:1 means something only while an interrupt is pending.
// - with several enabled sources active only the highest priority code shows.
// - a lower priority code shows only once the higher source has cleared.
// - codes by priority: 011 line status, 010 data ready, 110 timeout, 101 tx done.
// - bit 0 reads 0 while any enabled source is active, 1 otherwise.
// - framing flag bit 3 set on stop bit sampled 0, cleared by status read.
// - parity flag bit 2 set on head character parity error, cleared by status read.
// - in multidrop the parity flag shows 1 for address byte, 0 for data.
// - overrun flag bit 1 clears on a line status read.
// - fifo off: overrun when a new character lands before the last was read.
// - fifo on: overrun when a character completes while the fifo is full.
// - on fifo overrun the new character is dropped, not written.
// - data ready clears on buffer read or when the last fifo byte is read.
// - fifo off: data ready sets when a character enters the holding register.
// - fifo on: data ready sets whenever a character is written into the fifo.
`ifndef UISR_PARAMS_SVH
`define UISR_PARAMS_SVH

`define UISR_OFF_RBR 5'h00
`define UISR_OFF_IIR 5'h04
`define UISR_OFF_LSR 5'h08
`define UISR_OFF_CTRL 5'h0c
`define UISR_OFF_ISTS 5'h10
`define UISR_OFF_IMSK 5'h14

`define UISR_LSR_FE 3
`define UISR_LSR_PE 2
`define UISR_LSR_OE 1
`define UISR_LSR_DR 0

`define UISR_CTRL_FIFO 0
`define UISR_CTRL_MDROP 1
`define UISR_CTRL_IE_LS 2
`define UISR_CTRL_IE_RX 3
`define UISR_CTRL_IE_TO 4
`define UISR_CTRL_IE_TX 5
`define UISR_CTRL_TRIG_LO 8
`define UISR_CTRL_TRIG_HI 11

`define UISR_CTRL_RESET 12'h000
`define UISR_IMSK_RESET 4'h0
`define UISR_IIR_RESET 8'h01

`define UISR_FIFO_DEPTH 16

`endif

//--- logic/uisr_pkg.sv
/*
 Types for the UART interrupt identification and line status block.
 Constants live in uisr_params.svh.
*/
package uisr_pkg;

	typedef logic [7:0] uisr_byte_t;

	typedef enum logic [2:0] {
		UISR_CAUSE_NONE = 3'h0,
		UISR_CAUSE_LINE = 3'h3,
		UISR_CAUSE_RXDATA = 3'h2,
		UISR_CAUSE_TIMEOUT = 3'h6,
		UISR_CAUSE_TXDONE = 3'h5
	} uisr_cause_e;

	typedef enum logic [1:0] {
		UISR_FST_OFF = 2'h0,
		UISR_FST_MDROP = 2'h2,
		UISR_FST_ON = 2'h3
	} uisr_fifo_state_e;

endpackage

//--- logic/uisr_top.sv
/*
 Receive status, receive queue and interrupt identification of a UART.
 Assumes receiver, timeout and transmitter logic on the same clock, and
 an Avalon-MM master that holds each request until waitrequest is low.
*/
`timescale 1ns/10ps
`include "uisr_params.svh"

module uisr_top #(
	parameter int DEPTH = `UISR_FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// receiver side
	input wire logic rx_char_valid,
	input wire logic [7:0] rx_char_data,
	input wire logic rx_stop_bit,
	input wire logic rx_parity_bad,
	input wire logic rx_addr_mark,
	// other interrupt sources
	input wire logic rx_timeout,
	input wire logic tx_complete,
	// interrupt
	output logic irq
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	logic ack;
	logic [11:0] ctrl;
	logic [3:0] imsk;
	logic [3:0] ists;
	logic [9:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic fe;
	logic pe;
	logic oe;
	logic dr;
	logic [3:0] cap_lsr;
	logic [3:0] cap_ists;
	logic cap_data;

	logic fifo_on;
	logic fifo_act;
	logic acc_rd;
	logic acc_wr;
	logic [CW-1:0] cap;
	logic full;
	logic push;
	logic ovwr;
	logic ovr;
	logic pop;
	logic head_new;
	logic [9:0] head_word;
	logic [9:0] in_word;
	logic [CW-1:0] trig;
	logic rx_lvl;
	uisr_pkg::uisr_cause_e cause;
	uisr_pkg::uisr_fifo_state_e fst;
	logic [7:0] iir;
	logic [31:0] next_readdata;
	logic [3:0] ev;

	// bus handshake: one wait cycle per request
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;
	assign acc_rd = avs_read & ack;
	assign acc_wr = avs_write & ack;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack <= 1'b0;
		end else begin
			ack <= (avs_read | avs_write) & ~ack;
		end
	end

	// queue control; multidrop keeps the fifo out of the path
	assign fifo_on = ctrl[`UISR_CTRL_FIFO];
	assign fifo_act = fifo_on & ~ctrl[`UISR_CTRL_MDROP];
	assign cap = fifo_act ? CW'(DEPTH) : CW'(1);
	assign full = count >= cap;
	assign in_word = {(ctrl[`UISR_CTRL_MDROP] ? rx_addr_mark : rx_parity_bad),
		~rx_stop_bit, rx_char_data};
	assign pop = acc_rd && avs_address == `UISR_OFF_RBR && cap_data && count != '0;
	assign ovr = rx_char_valid & full & ~pop;
	assign push = rx_char_valid & ~full;
	assign ovwr = rx_char_valid & full & ~pop & ~fifo_act;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push | (rx_char_valid & pop)) begin
				wr_ptr <= AW'(wr_ptr + 1'b1);
			end
			if (pop) begin
				rd_ptr <= AW'(rd_ptr + 1'b1);
			end
			if ((push | (rx_char_valid & pop)) & ~pop) begin
				count <= CW'(count + 1'b1);
			end else if (pop & ~(rx_char_valid)) begin
				count <= CW'(count - 1'b1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (push | (rx_char_valid & pop)) begin
			mem[wr_ptr] <= in_word;
		end else if (ovwr) begin
			mem[rd_ptr] <= in_word;
		end
	end

	// a new character reaching the head of the queue
	always_comb begin
		head_new = 1'b0;
		head_word = in_word;
		if (rx_char_valid & (count == '0 | ovwr | (pop & count == CW'(1)))) begin
			head_new = 1'b1;
		end else if (pop & count > CW'(1)) begin
			head_new = 1'b1;
			head_word = mem[AW'(rd_ptr + 1'b1)];
		end
	end

	// line status flags; a set in the clearing cycle wins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fe <= 1'b0;
			pe <= 1'b0;
			oe <= 1'b0;
			dr <= 1'b0;
		end else begin
			if (head_new & head_word[8]) begin
				fe <= 1'b1;
			end else if (acc_rd && avs_address == `UISR_OFF_LSR && cap_lsr[`UISR_LSR_FE]) begin
				fe <= 1'b0;
			end
			if (head_new) begin
				pe <= head_word[9];
			end else if (acc_rd && avs_address == `UISR_OFF_LSR && cap_lsr[`UISR_LSR_PE]) begin
				pe <= 1'b0;
			end
			if (ovr) begin
				oe <= 1'b1;
			end else if (acc_rd && avs_address == `UISR_OFF_LSR && cap_lsr[`UISR_LSR_OE]) begin
				oe <= 1'b0;
			end
			if (rx_char_valid) begin
				dr <= 1'b1;
			end else if (pop & count == CW'(1)) begin
				dr <= 1'b0;
			end
		end
	end

	// interrupt cause priority
	assign trig = (ctrl[`UISR_CTRL_TRIG_HI:`UISR_CTRL_TRIG_LO] == 4'h0) ? CW'(1) :
		CW'(ctrl[`UISR_CTRL_TRIG_HI:`UISR_CTRL_TRIG_LO]);
	assign rx_lvl = fifo_act ? (count >= trig) : dr;

	always_comb begin
		cause = uisr_pkg::UISR_CAUSE_NONE;
		if (ctrl[`UISR_CTRL_IE_LS] & (fe | pe | oe)) begin
			cause = uisr_pkg::UISR_CAUSE_LINE;
		end else if (ctrl[`UISR_CTRL_IE_RX] & rx_lvl) begin
			cause = uisr_pkg::UISR_CAUSE_RXDATA;
		end else if (ctrl[`UISR_CTRL_IE_TO] & rx_timeout) begin
			cause = uisr_pkg::UISR_CAUSE_TIMEOUT;
		end else if (ctrl[`UISR_CTRL_IE_TX] & tx_complete) begin
			cause = uisr_pkg::UISR_CAUSE_TXDONE;
		end
	end

	always_comb begin
		if (!fifo_on) begin
			fst = uisr_pkg::UISR_FST_OFF;
		end else if (ctrl[`UISR_CTRL_MDROP]) begin
			fst = uisr_pkg::UISR_FST_MDROP;
		end else begin
			fst = uisr_pkg::UISR_FST_ON;
		end
	end

	// code is zero when nothing pends, reserved bits zero
	assign iir = {fst, 2'h0, cause, cause == uisr_pkg::UISR_CAUSE_NONE};

	// control and mask registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= `UISR_CTRL_RESET;
			imsk <= `UISR_IMSK_RESET;
		end else if (acc_wr) begin
			if (avs_address == `UISR_OFF_CTRL) begin
				if (avs_byteenable[0]) begin
					ctrl[7:0] <= avs_writedata[7:0];
				end
				if (avs_byteenable[1]) begin
					ctrl[11:8] <= avs_writedata[11:8];
				end
			end
			if (avs_address == `UISR_OFF_IMSK && avs_byteenable[0]) begin
				imsk <= avs_writedata[3:0];
			end
		end
	end

	// sticky events: rx char, overrun, framing, parity; cleared by read
	assign ev = {rx_char_valid & in_word[9], rx_char_valid & in_word[8], ovr, rx_char_valid};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ists <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (ev[i]) begin
					ists[i] <= 1'b1;
				end else if (acc_rd && avs_address == `UISR_OFF_ISTS && cap_ists[i]) begin
					ists[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(ists & imsk);
		end
	end

	// read data and capture of what a read will clear
	always_comb begin
		next_readdata = 32'h0;
		unique case (avs_address)
			`UISR_OFF_RBR: next_readdata = {24'h0, (count != '0) ? mem[rd_ptr][7:0] : 8'h00};
			`UISR_OFF_IIR: next_readdata = {24'h0, iir};
			`UISR_OFF_LSR: next_readdata = {28'h0, fe, pe, oe, dr};
			`UISR_OFF_CTRL: next_readdata = {20'h0, ctrl};
			`UISR_OFF_ISTS: next_readdata = {28'h0, ists};
			`UISR_OFF_IMSK: next_readdata = {28'h0, imsk};
			default: next_readdata = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			avs_readdata <= 32'h0;
			cap_lsr <= 4'h0;
			cap_ists <= 4'h0;
			cap_data <= 1'b0;
		end else if (avs_read & ~ack) begin
			avs_readdata <= next_readdata;
			cap_lsr <= {fe, pe, oe, dr};
			cap_ists <= ists;
			cap_data <= count != '0;
		end
	end

endmodule

//--- sim/uisr_chk.sv
/* bus and status port assertions for uisr_top
 bound from the bench top file, one clock domain */
`timescale 1ns/10ps
module uisr_chk (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// watched ports
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic rx_char_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire logic ack = avs_read && !avs_waitrequest;
	wire logic a4 = ack && avs_address == 5'h04;
	wire logic a8 = ack && avs_address == 5'h08;
	a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("waitrequest low in first request cycle");
	a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("more than one wait cycle");
	a_iir_rsvd: assert property (a4 |-> avs_readdata[5:4] == 2'h0)
		else $error("ident reserved bits set");
	a_iir_pend: assert property (a4 |-> avs_readdata[0] == (avs_readdata[3:1] == 3'h0))
		else $error("pending flag and cause disagree");
	a_iir_code: assert property (a4 |-> avs_readdata[3:1] inside {3'h0, 3'h2, 3'h3, 3'h5, 3'h6})
		else $error("illegal cause code");
	a_iir_fifo: assert property (a4 |-> avs_readdata[7:6] != 2'h1)
		else $error("illegal fifo state field");
	a_data_upper: assert property (ack |-> avs_readdata[31:12] == 20'h0)
		else $error("upper read bits set");
	a_lsr_clear: assert property (a8 && !rx_char_valid ##1 !rx_char_valid [*2] ##1 a8
		|-> avs_readdata[3:1] == 3'h0)
		else $error("error flags survive status read");
endmodule

//--- sim/uisr_rx_model.sv
/* remote serial device handing complete characters to uisr_top
 driven by the bench through send, same clock */
`timescale 1ns/10ps
module uisr_rx_model (
	// clock
	input wire logic clk,
	// character out
	output logic rx_char_valid,
	output logic [7:0] rx_char_data,
	output logic rx_stop_bit,
	output logic rx_parity_bad,
	output logic rx_addr_mark
);
	initial {rx_char_valid, rx_char_data, rx_stop_bit, rx_parity_bad, rx_addr_mark} = '0;
	// f is stop level, parity bad, address mark; lines inverted once released
	task automatic send(input logic [7:0] d, input logic [2:0] f);
		@(posedge clk);
		rx_char_valid <= 1'b1;
		rx_char_data <= d;
		{rx_stop_bit, rx_parity_bad, rx_addr_mark} <= f;
		@(posedge clk);
		rx_char_valid <= 1'b0;
		rx_char_data <= ~d;
		{rx_stop_bit, rx_parity_bad, rx_addr_mark} <= ~f;
	endtask
endmodule

//--- sim/uisr_top_bench.sv
/* self-checking bench for uisr_top with the receive partner model
 needs uisr_chk and uisr_rx_model compiled first */
`timescale 1ns/10ps
module uisr_top_bench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic rx_timeout = 1'b0;
	logic tx_complete = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, irq, rx_char_valid, rx_stop_bit, rx_parity_bad, rx_addr_mark;
	logic [7:0] rx_char_data;
	logic [31:0] q[$];
	logic [7:0] d[5];
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	always #2.5 clk = ~clk;
	uisr_top #(.DEPTH(4)) uisr_top_i (.clk, .nrst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .rx_char_valid,
		.rx_char_data, .rx_stop_bit, .rx_parity_bad, .rx_addr_mark, .rx_timeout, .tx_complete,
		.irq);
	uisr_rx_model uisr_rx_model_i (.clk, .rx_char_valid, .rx_char_data, .rx_stop_bit,
		.rx_parity_bad, .rx_addr_mark);
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one request held until waitrequest low; reads note their expectation
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v);
		@(posedge clk);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= w ? v : 32'h0;
		if (!w)
			q.push_back(v);
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	always @(posedge clk)
		if (avs_read && avs_waitrequest === 1'b0)
			check($sformatf("read %h", avs_address), avs_readdata, q.pop_front());
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			tally_and_finish;
		end
	end
	initial begin
		void'($urandom(18));
		for (int i = 0; i < 5; i++)
			d[i] = 8'($urandom);
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		bus(0, 5'h04, 32'h01);
		bus(1, 5'h04, 32'hff);
		bus(0, 5'h04, 32'h01);
		bus(0, 5'h18, 32'h0);
		bus(1, 5'h0c, 32'h3c);
		uisr_rx_model_i.send(d[0], 3'h4);
		check("irq masked", irq, 1'b0);
		bus(1, 5'h14, 32'h1);
		repeat (2) @(posedge clk);
		check("irq", irq, 1'b1);
		bus(0, 5'h04, 32'h04);
		bus(0, 5'h10, 32'h1);
		repeat (2) @(posedge clk);
		check("irq cleared", irq, 1'b0);
		bus(0, 5'h08, 32'h1);
		bus(0, 5'h00, {24'h0, d[0]});
		bus(0, 5'h08, 32'h0);
		uisr_rx_model_i.send(d[1], 3'h4);
		uisr_rx_model_i.send(d[2], 3'h2);
		bus(0, 5'h04, 32'h06);
		bus(0, 5'h08, 32'hf);
		bus(0, 5'h08, 32'h1);
		bus(0, 5'h04, 32'h04);
		bus(0, 5'h00, {24'h0, d[2]});
		tx_complete <= 1'b1;
		rx_timeout <= 1'b1;
		bus(0, 5'h04, 32'h0c);
		rx_timeout <= 1'b0;
		bus(0, 5'h04, 32'h0a);
		tx_complete <= 1'b0;
		bus(1, 5'h0c, 32'h3d);
		bus(0, 5'h04, 32'hc1);
		for (int i = 0; i < 5; i++)
			uisr_rx_model_i.send(d[i], 3'h4);
		bus(0, 5'h08, 32'h3);
		for (int i = 0; i < 4; i++)
			bus(0, 5'h00, {24'h0, d[i]});
		bus(0, 5'h08, 32'h0);
		bus(0, 5'h00, 32'h0);
		bus(1, 5'h0c, 32'h3f);
		bus(0, 5'h04, 32'h81);
		uisr_rx_model_i.send(d[3], 3'h5);
		bus(0, 5'h08, 32'h5);
		bus(0, 5'h08, 32'h1);
		bus(0, 5'h00, {24'h0, d[3]});
		uisr_rx_model_i.send(d[4], 3'h4);
		bus(0, 5'h08, 32'h1);
		bus(1, 5'h0c, 32'h23d);
		bus(0, 5'h04, 32'hc1);
		bus(0, 5'h10, 32'hf);
		bus(0, 5'h10, 32'h0);
		uisr_rx_model_i.send(d[0], 3'h4);
		bus(0, 5'h04, 32'hc4);
		tally_and_finish;
	end
endmodule
bind uisr_top uisr_chk uisr_chk_i (.clk, .nrst, .avs_address, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .rx_char_valid);
